// >>> mcu_reset_sources_and_flags.sv
// Operation
// - Power-on reset clears program counter to zero
// - Power-on presets port data and direction high
// - Hold reset for 50ms after power-on
// - Ignore low-supply dips shorter than minimum duration
// - Low-voltage reset is full, sets flag bit 2 (code leaves the flag clear if it is detected during a full hold)
// - Decode four threshold select codes to levels
// - Bad threshold code: reset, restore default
// - Bad threshold code sets flag bit 1
// - Low-voltage reset keeps threshold register contents
// - Threshold register powers up as 0x55
// - Low-voltage reset disabled in power-down
// - Source flags sticky; only software zero clears
// - Flag bits 7 to 3 read zero
// - Normal watchdog time-out: full reset, set TO
// - Sleep time-out clears PC and SP only
// - TO and POWERDOWN_STATUS_FLAG follow reset cause table
// - Bad watchdog enable code: reset, set flag
//
// Design decisions made here: the register addresses and the AHB-Lite register port.
`include "reset_seq_defines.svh"

module mcu_reset_sources_and_flags
  import reset_seq_pkg::*;
#(
  parameter int SLOW_DIV = `SLOW_DIV_CYCLES,
  parameter int STARTUP_TICKS = `STARTUP_RESET_TICKS,
  parameter int WDT_TICKS = `WDT_RESET_TICKS,
  parameter int WAKE_TICKS = `WAKEUP_START_TICKS,
  parameter int MIN_LV_TICKS = `MIN_LOWVOLT_TICKS
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic supply_low,
  input wire logic wdt_timeout,
  input wire logic [4:0] watchdog_enable_code,
  input wire logic sleep_mode,
  input wire logic idle_mode,
  input wire logic powerdown_mode,
  input wire logic clear_status_flags,
  output logic sys_reset_n,
  output logic pc_sp_clear,
  output logic port_preset,
  output logic [1:0] threshold_level,
  output logic timeout_status_flag,
  output logic powerdown_status_flag,
  output logic irq
);

  // Whole state of the block
  typedef struct packed {
    seq_state_type seq;              // Sequencer phase
    logic [`HOLD_W-1:0] hold_cnt;    // Slow ticks left in the hold
    logic [`DIV_W-1:0] div_cnt;      // Slow oscillator divider
    logic slow_tick;                 // One-cycle slow clock enable
    logic [7:0] thr_sel;             // Threshold select register
    logic lowvolt_reset_flag;
    logic threshold_reg_reset_flag;
    logic watchdog_reg_reset_flag;
    logic timeout_status_flag;
    logic powerdown_status_flag;
    logic [1:0] thr_bad_cnt;         // Ticks since a bad threshold code
    logic [1:0] wdc_bad_cnt;         // Ticks since a bad watchdog code
    logic [`EV_W-1:0] irq_stat;      // Sticky event bits
    logic [`EV_W-1:0] irq_en;        // Event enables
    logic wr_pend;                   // Write data phase pending
    logic [7:0] wr_addr;             // Address of the pending write
    logic [31:0] rdata;              // Read data for the data phase
  } state_type;

  state_type state_reg;
  state_type state_next;
  logic lowvolt_valid;

  // Sustained low supply, only while not powered down
  lowvolt_filter #(
    .MIN_TICKS(MIN_LV_TICKS)
  ) u_filter (
    .hclk(hclk),
    .hresetn(hresetn),
    .slow_tick(state_reg.slow_tick),
    .enable(!powerdown_mode),
    .supply_low(supply_low),
    .lowvolt_valid(lowvolt_valid)
  );

  // Threshold code checks
  function automatic logic thr_code_ok(input logic [7:0] code);
    thr_code_ok = (code == `THR_CODE_2V10) || (code == `THR_CODE_2V55) ||
                  (code == `THR_CODE_3V15) || (code == `THR_CODE_3V80);
  endfunction : thr_code_ok

  // Flag register image with unused bits zero
  function automatic logic [31:0] flags_image(input state_type s);
    flags_image = '0; // Bits 7 to 3 stay zero
    flags_image[`FLAG_LOWVOLT_BIT] = s.lowvolt_reset_flag;
    flags_image[`FLAG_THR_REG_BIT] = s.threshold_reg_reset_flag;
    flags_image[`FLAG_WDT_REG_BIT] = s.watchdog_reg_reset_flag;
  endfunction : flags_image

  // Level decode for the supply comparator
  always_comb begin
    case (state_reg.thr_sel)
      `THR_CODE_2V55: threshold_level = LEVEL_2V55;
      `THR_CODE_3V15: threshold_level = LEVEL_3V15;
      `THR_CODE_3V80: threshold_level = LEVEL_3V80;
      default: threshold_level = LEVEL_2V10;
    endcase
  end

  // Next-state logic: divider, sources, sequencer, flags and bus slave
  always_comb begin
    logic addr_phase;
    logic thr_bad;
    logic wdc_bad;
    logic thr_trig;
    logic wdc_trig;
    logic wdt_full;
    logic wdt_partial;
    logic full_trig;
    logic [`EV_W-1:0] ev;
    logic [7:0] raddr;
    addr_phase = 1'b0;
    thr_bad = 1'b0;
    wdc_bad = 1'b0;
    thr_trig = 1'b0;
    wdc_trig = 1'b0;
    wdt_full = 1'b0;
    wdt_partial = 1'b0;
    full_trig = 1'b0;
    ev = '0;
    raddr = haddr[7:0];
    state_next = state_reg;

    // Slow oscillator as a one-cycle enable from the bus clock
    state_next.slow_tick = 1'b0;
    if (state_reg.div_cnt == `DIV_W'(SLOW_DIV - 1)) begin
      state_next.div_cnt = '0;
      state_next.slow_tick = 1'b1;
    end else begin
      state_next.div_cnt = state_reg.div_cnt + `DIV_W'(1);
    end

    // Bad threshold code counts slow ticks, fires after 2 to 3 of them
    thr_bad = !thr_code_ok(state_reg.thr_sel);
    if (!thr_bad) begin
      state_next.thr_bad_cnt = '0;
    end else if (state_reg.slow_tick) begin
      if (state_reg.thr_bad_cnt == 2'(`BAD_CODE_TICKS)) begin
        thr_trig = 1'b1;
      end else begin
        state_next.thr_bad_cnt = state_reg.thr_bad_cnt + 2'(1);
      end
    end

    // Same timing for a bad watchdog enable code
    wdc_bad = (watchdog_enable_code != `WDT_CODE_DISABLE) &&
              (watchdog_enable_code != `WDT_CODE_ENABLE);
    if (!wdc_bad) begin
      state_next.wdc_bad_cnt = '0;
    end else if (state_reg.slow_tick) begin
      if (state_reg.wdc_bad_cnt == 2'(`BAD_CODE_TICKS)) begin
        wdc_trig = 1'b1;
        state_next.wdc_bad_cnt = '0;
      end else begin
        state_next.wdc_bad_cnt = state_reg.wdc_bad_cnt + 2'(1);
      end
    end

    // Watchdog time-out splits on the power mode
    wdt_partial = wdt_timeout && (sleep_mode || idle_mode);
    wdt_full = wdt_timeout && !sleep_mode && !idle_mode;
    full_trig = lowvolt_valid || thr_trig || wdc_trig || wdt_full;

    // Sequencer: a new full cause always restarts the hold
    case (state_reg.seq)
      SEQ_POR_HOLD, SEQ_FULL_HOLD: begin
        if (full_trig) begin
          state_next.seq = SEQ_FULL_HOLD;
        end else if (state_reg.slow_tick) begin
          if (state_reg.hold_cnt == '0) begin
            state_next.seq = SEQ_RUN; // Released on slow clock
          end else begin
            state_next.hold_cnt = state_reg.hold_cnt - `HOLD_W'(1);
          end
        end
      end
      SEQ_RUN: begin
        if (full_trig) begin
          state_next.seq = SEQ_FULL_HOLD;
        end else if (wdt_partial) begin
          state_next.seq = SEQ_PARTIAL_HOLD; // PC and SP only
          state_next.hold_cnt = `HOLD_W'(WAKE_TICKS);
        end
      end
      SEQ_PARTIAL_HOLD: begin
        if (full_trig) begin
          state_next.seq = SEQ_FULL_HOLD;
        end else if (wdt_partial) begin
          // A fresh time-out while waking restarts the delay
          state_next.hold_cnt = `HOLD_W'(WAKE_TICKS);
        end else if (state_reg.slow_tick) begin
          if (state_reg.hold_cnt == '0) begin
            state_next.seq = SEQ_RUN; // Wake-up delay over
          end else begin
            state_next.hold_cnt = state_reg.hold_cnt - `HOLD_W'(1);
          end
        end
      end
      default: begin
        state_next.seq = SEQ_FULL_HOLD;
      end
    endcase

    // Hold length follows the cause; watchdog time-out holds shorter
    if (full_trig) begin
      if (wdt_full && !lowvolt_valid && !thr_trig && !wdc_trig) begin
        state_next.hold_cnt = `HOLD_W'(WDT_TICKS);
      end else begin
        state_next.hold_cnt = `HOLD_W'(STARTUP_TICKS);
      end
    end

    // Status flags; a low-voltage reset leaves both as they were
    if (clear_status_flags) begin
      state_next.timeout_status_flag = 1'b0;
      state_next.powerdown_status_flag = 1'b0;
    end
    if (wdt_full) begin
      state_next.timeout_status_flag = 1'b1;
    end
    if (wdt_partial) begin
      state_next.timeout_status_flag = 1'b1;
      state_next.powerdown_status_flag = 1'b1;
    end

    // Bus data phase: writes land one cycle after their address phase
    state_next.wr_pend = 1'b0;
    if (state_reg.wr_pend) begin
      case (state_reg.wr_addr)
        `THR_SEL_ADDR: begin
          state_next.thr_sel = hwdata[7:0];
        end
        `FLAGS_ADDR: begin
          // Zero clears, one is ignored
          if (!hwdata[`FLAG_LOWVOLT_BIT]) begin
            state_next.lowvolt_reset_flag = 1'b0;
          end
          if (!hwdata[`FLAG_THR_REG_BIT]) begin
            state_next.threshold_reg_reset_flag = 1'b0;
          end
          if (!hwdata[`FLAG_WDT_REG_BIT]) begin
            state_next.watchdog_reg_reset_flag = 1'b0;
          end
        end
        `IRQ_CLR_ADDR: begin
          state_next.irq_stat = state_reg.irq_stat & ~hwdata[`EV_W-1:0];
        end
        `IRQ_EN_ADDR: begin
          state_next.irq_en = hwdata[`EV_W-1:0];
        end
        default: begin
          // Read-only or unmapped: write dropped
        end
      endcase
    end

    // Bad code restores the register, overriding any write
    // No other cause touches it, so a low-voltage hold keeps it
    if (thr_trig) begin
      state_next.thr_sel = `THR_SEL_RESET;
    end

    // Hardware sets after software clears, so a set is never lost
    if (lowvolt_valid && state_reg.seq != SEQ_FULL_HOLD) begin
      state_next.lowvolt_reset_flag = 1'b1;
    end
    if (thr_trig) begin
      state_next.threshold_reg_reset_flag = 1'b1;
    end
    if (wdc_trig) begin
      state_next.watchdog_reg_reset_flag = 1'b1;
    end

    // Interrupt events, also set over a same-cycle clear
    ev[`EV_LOWVOLT] = lowvolt_valid && state_reg.seq != SEQ_FULL_HOLD;
    ev[`EV_THR_REG] = thr_trig;
    ev[`EV_WDT_REG] = wdc_trig;
    ev[`EV_WDT_TIMEOUT] = wdt_timeout;
    state_next.irq_stat = state_next.irq_stat | ev;

    // Address phase: latch writes, prepare read data
    addr_phase = hsel && htrans[1] && hready;
    if (addr_phase) begin
      state_next.wr_pend = hwrite;
      state_next.wr_addr = raddr;
      state_next.rdata = '0;
      if (!hwrite) begin
        case (raddr)
          `THR_SEL_ADDR: state_next.rdata = {24'h000000, state_reg.thr_sel};
          `FLAGS_ADDR: state_next.rdata = flags_image(state_reg);
          `IRQ_STAT_ADDR: state_next.rdata = {28'h0000000, state_reg.irq_stat};
          `IRQ_EN_ADDR: state_next.rdata = {28'h0000000, state_reg.irq_en};
          `STATUS_ADDR: begin
            state_next.rdata = {24'h000000, 2'b00, state_reg.seq, threshold_level,
                                state_reg.powerdown_status_flag,
                                state_reg.timeout_status_flag};
          end
          default: state_next.rdata = '0;
        endcase
      end
    end
  end

  // State register; power-on values come only from here
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= '0;
      state_reg.seq <= SEQ_POR_HOLD;
      state_reg.hold_cnt <= `HOLD_W'(`STARTUP_RESET_TICKS);
      state_reg.thr_sel <= `THR_SEL_RESET;
      state_reg.timeout_status_flag <= 1'b0;
      state_reg.powerdown_status_flag <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Reset outputs decoded from the sequencer phase
  assign sys_reset_n = (state_reg.seq == SEQ_RUN) || (state_reg.seq == SEQ_PARTIAL_HOLD);
  assign pc_sp_clear = (state_reg.seq != SEQ_RUN);
  assign port_preset = (state_reg.seq == SEQ_POR_HOLD);
  assign timeout_status_flag = state_reg.timeout_status_flag;
  assign powerdown_status_flag = state_reg.powerdown_status_flag;
  assign irq = |(state_reg.irq_stat & state_reg.irq_en);

  // Zero-wait slave, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = state_reg.rdata;

endmodule : mcu_reset_sources_and_flags

// >>> reset_seq_defines.svh
`ifndef RESET_SEQ_DEFINES_SVH
`define RESET_SEQ_DEFINES_SVH

// Clock rates, in kHz
`define HCLK_KHZ 25000
`define SLOW_OSC_KHZ 32

// Bus clocks per slow oscillator period, rounded down
`define SLOW_DIV_CYCLES (`HCLK_KHZ / `SLOW_OSC_KHZ)

// Start-up delays in microseconds, as printed
`define STARTUP_RESET_DELAY_US 50000
`define WDT_RESET_DELAY_US 16700

// Least times round up to whole slow oscillator ticks
`define STARTUP_RESET_TICKS ((`STARTUP_RESET_DELAY_US * `SLOW_OSC_KHZ + 999) / 1000)
`define WDT_RESET_TICKS ((`WDT_RESET_DELAY_US * `SLOW_OSC_KHZ + 999) / 1000)

// Default wake-up delay and least low-supply duration, in slow ticks
`define WAKEUP_START_TICKS 16
`define MIN_LOWVOLT_TICKS 4

// Slow ticks after a bad control code before the reset fires
`define BAD_CODE_TICKS 2

// Counter widths
`define HOLD_W 16
`define DIV_W 16
`define FILT_W 8

// Threshold select codes and reset value
`define THR_CODE_2V10 8'h55
`define THR_CODE_2V55 8'h33
`define THR_CODE_3V15 8'h99
`define THR_CODE_3V80 8'hAA
`define THR_SEL_RESET 8'h55

// Watchdog enable field codes
`define WDT_CODE_DISABLE 5'h15
`define WDT_CODE_ENABLE 5'h0A

// Reset source flag positions
`define FLAG_WDT_REG_BIT 0
`define FLAG_THR_REG_BIT 1
`define FLAG_LOWVOLT_BIT 2
`define FLAGS_RESET 3'h0

// Interrupt event positions
`define EV_LOWVOLT 0
`define EV_THR_REG 1
`define EV_WDT_REG 2
`define EV_WDT_TIMEOUT 3
`define EV_W 4

// Register byte addresses
`define THR_SEL_ADDR 8'h00
`define FLAGS_ADDR 8'h04
`define IRQ_STAT_ADDR 8'h08
`define IRQ_CLR_ADDR 8'h0C
`define IRQ_EN_ADDR 8'h10
`define STATUS_ADDR 8'h14

`endif

// >>> reset_seq_pkg.sv
`include "reset_seq_defines.svh"

package reset_seq_pkg;

  // Reset sequencer phases
  typedef enum logic [1:0] {
    SEQ_POR_HOLD,
    SEQ_RUN,
    SEQ_FULL_HOLD,
    SEQ_PARTIAL_HOLD
  } seq_state_type;

  // Decoded low-voltage threshold level
  typedef enum logic [1:0] {
    LEVEL_2V10,
    LEVEL_2V55,
    LEVEL_3V15,
    LEVEL_3V80
  } thr_level_type;

endpackage : reset_seq_pkg

// >>> lowvolt_filter.sv
`include "reset_seq_defines.svh"

// Rejects low-supply indications that do not outlast the least duration
module lowvolt_filter
  import reset_seq_pkg::*;
#(
  parameter int MIN_TICKS = `MIN_LOWVOLT_TICKS
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic slow_tick,
  input wire logic enable,
  input wire logic supply_low,
  output logic lowvolt_valid
);

  // Whole state of the filter
  typedef struct packed {
    logic [`FILT_W-1:0] cnt; // Slow ticks seen while low
    logic valid;             // Indication accepted
  } filt_state_type;

  filt_state_type state_reg;
  filt_state_type state_next;

  // Count ticks of a continuous low supply; any break restarts the count
  always_comb begin
    state_next = state_reg;
    if (!enable || !supply_low) begin
      state_next.cnt = '0; // Short dips are forgotten
      state_next.valid = 1'b0;
    end else if (slow_tick && !state_reg.valid) begin
      state_next.cnt = state_reg.cnt + `FILT_W'(1);
      // Must stay low longer than the least duration
      if (state_reg.cnt >= `FILT_W'(MIN_TICKS)) begin
        state_next.valid = 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign lowvolt_valid = state_reg.valid;

endmodule : lowvolt_filter

// >>> supply_wdt_model.sv
`include "reset_seq_defines.svh"

// Far side: supply comparator and watchdog timer
module supply_wdt_model (
  input wire logic hclk,
  output logic supply_low,
  output logic wdt_timeout,
  output logic [4:0] watchdog_enable_code
);
  timeunit 1ns;
  timeprecision 1ns;
  // Quiet supply, watchdog enabled as after power-on
  initial begin
    supply_low = 1'b0;
    wdt_timeout = 1'b0;
    watchdog_enable_code = `WDT_CODE_ENABLE;
  end

  // Supply below threshold for n clock edges
  task dip(input int n);
    @(posedge hclk);
    supply_low <= 1'b1;
    repeat (n) @(posedge hclk);
    supply_low <= 1'b0;
  endtask : dip

  // One-cycle overflow pulse; a level would retrigger
  task bark;
    @(posedge hclk);
    wdt_timeout <= 1'b1;
    @(posedge hclk);
    wdt_timeout <= 1'b0;
  endtask : bark

  // Enable field as software or noise leaves it
  task set_code(input logic [4:0] c);
    @(posedge hclk);
    watchdog_enable_code <= c;
  endtask : set_code
endmodule : supply_wdt_model

// >>> reset_flags_chk.sv
// Watches reset outputs against their causes
module reset_flags_chk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic supply_low,
  input wire logic wdt_timeout,
  input wire logic sleep_mode,
  input wire logic idle_mode,
  input wire logic clear_status_flags,
  input wire logic sys_reset_n,
  input wire logic pc_sp_clear,
  input wire logic port_preset,
  input wire logic timeout_status_flag,
  input wire logic powerdown_status_flag
);
  timeunit 1ns;
  timeprecision 1ns;
  // One domain, so one clock and one disable
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_preset_in_hold:
    assert property (port_preset |-> !sys_reset_n && pc_sp_clear)
      else $error("port preset outside power-on hold");
  a_hold_clears_pc:
    assert property (!sys_reset_n |-> pc_sp_clear)
      else $error("full reset without pc clear");
  a_wdt_full_reset:
    assert property (wdt_timeout && !sleep_mode && !idle_mode && sys_reset_n |=> !sys_reset_n)
      else $error("normal time-out gave no full reset");
  a_wdt_sets_to:
    assert property (wdt_timeout |=> timeout_status_flag)
      else $error("time-out flag not set");
  a_sleep_partial:
    assert property (wdt_timeout && (sleep_mode || idle_mode) && sys_reset_n
      |=> sys_reset_n && pc_sp_clear)
      else $error("sleep time-out not partial");
  a_sleep_sets_pdf:
    assert property (wdt_timeout && (sleep_mode || idle_mode) |=> powerdown_status_flag)
      else $error("sleep time-out left power-down flag");
  a_normal_keeps_pdf:
    assert property (wdt_timeout && !sleep_mode && !idle_mode && !clear_status_flags
      |=> powerdown_status_flag == $past(powerdown_status_flag))
      else $error("normal time-out changed power-down flag");
  a_por_flags_zero:
    assert property ($rose(hresetn) |-> !timeout_status_flag && !powerdown_status_flag)
      else $error("status flags not clear after power-on");
  a_hold_min_len:
    assert property ($fell(sys_reset_n) |-> !sys_reset_n [*5])
      else $error("full reset released too soon");
  a_hold_bounded:
    assert property ($fell(sys_reset_n) && !supply_low |-> ##[1:100] sys_reset_n)
      else $error("full reset never released");
endmodule : reset_flags_chk

bind mcu_reset_sources_and_flags reset_flags_chk i_chk (.*);

// >>> test_mcu_reset_sources_and_flags.sv
`include "reset_seq_defines.svh"

module test_mcu_reset_sources_and_flags import reset_seq_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans, threshold_level;
  logic [2:0] hsize;
  logic supply_low, wdt_timeout, sleep_mode, idle_mode, powerdown_mode;
  logic clear_status_flags, sys_reset_n, pc_sp_clear, port_preset;
  logic timeout_status_flag, powerdown_status_flag;
  logic [4:0] watchdog_enable_code;
  int errors, cmp_count, n;
  // Table rows: threshold code and the level it selects
  typedef struct packed {logic [7:0] code; logic [1:0] lvl;} row_type;
  row_type rows[4] = '{'{8'h55, 2'h0}, '{8'h33, 2'h1}, '{8'h99, 2'h2}, '{8'hAA, 2'h3}};

  // Short holds keep the run brief; wake-up and filter keep their defaults
  mcu_reset_sources_and_flags #(.SLOW_DIV(4), .STARTUP_TICKS(3), .WDT_TICKS(2)) i_dut (.*);
  supply_wdt_model i_model (.*);
  assign hready = hreadyout;
  always #20 hclk = ~hclk;

  task summarize;
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Bounded wait for the slave's ready at a rising edge
  task wait_ready;
    for (int i = 0; i < 20; i++) begin
      @(posedge hclk);
      if (hreadyout === 1'b1) return;
    end
    errors++;
    summarize;
  endtask : wait_ready

  // One single word transfer; read data taken at the data-phase edge
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    hsize <= 3'h2;
    wait_ready;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready;
    q = hrdata;
  endtask : bus

  task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, a, 32'h0);
    chk(nm, e, q);
    chk("hresp", 32'h0, 32'(hresp));
  endtask : rd

  // Bounded wait for the system reset level, counting cycles
  task wait_lvl(input logic v, output int c);
    c = 0;
    while (sys_reset_n !== v) begin
      @(posedge hclk);
      #1;
      c++;
      if (c > 9000) begin
        errors++;
        summarize;
      end
    end
  endtask : wait_lvl

  initial begin
    {hclk, hresetn, hsel, hwrite, sleep_mode, idle_mode, powerdown_mode} = 7'h0;
    {haddr, hwdata, htrans, clear_status_flags} = '0;
    hsize = 3'h2;
    errors = 0;
    cmp_count = 0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    #1;
    chk("port_preset", 32'h1, 32'(port_preset));
    chk("pc_sp_clear", 32'h1, 32'(pc_sp_clear));
    chk("to_pdf", 32'h0, 32'({timeout_status_flag, powerdown_status_flag}));
    rd(`THR_SEL_ADDR, 32'h55, "thr_por");
    rd(`FLAGS_ADDR, 32'h0, "flags_por");
    // The power-on hold uses the full tick count, not the parameter
    wait_lvl(1'b1, n);
    chk("por_hold", 32'h1, 32'(n >= `STARTUP_RESET_TICKS * 4 - 20));
    chk("preset_off", 32'h0, 32'({port_preset, pc_sp_clear}));
    $display("power-on test done");
    foreach (rows[i]) begin
      bus(1'b1, `THR_SEL_ADDR, 32'(rows[i].code));
      rd(`THR_SEL_ADDR, 32'(rows[i].code), "thr_rw");
      #1;
      chk("level", 32'(rows[i].lvl), 32'(threshold_level));
      chk("no_reset", 32'h1, 32'(sys_reset_n));
    end
    $display("threshold table done");
    // A dip of at most two slow ticks must be ignored
    i_model.dip(5);
    repeat (40) @(posedge hclk);
    #1;
    chk("short_dip", 32'h1, 32'(sys_reset_n));
    @(posedge hclk);
    powerdown_mode <= 1'b1;
    i_model.dip(40);
    repeat (20) @(posedge hclk);
    #1;
    chk("pd_dip", 32'h1, 32'(sys_reset_n));
    @(posedge hclk);
    powerdown_mode <= 1'b0;
    rd(`FLAGS_ADDR, 32'h0, "flags_none");
    i_model.dip(40);
    #1;
    chk("lv_reset", 32'h0, 32'(sys_reset_n));
    wait_lvl(1'b1, n);
    rd(`FLAGS_ADDR, 32'h4, "flag_lv");
    rd(`THR_SEL_ADDR, 32'hAA, "thr_kept");
    chk("to_pdf_lv", 32'h0, 32'({timeout_status_flag, powerdown_status_flag}));
    bus(1'b1, `FLAGS_ADDR, 32'hFF);
    rd(`FLAGS_ADDR, 32'h4, "flag_ones");
    bus(1'b1, `FLAGS_ADDR, 32'h0);
    rd(`FLAGS_ADDR, 32'h0, "flag_clr");
    $display("low-voltage test done");
    // Undefined threshold code: delayed reset and restore
    bus(1'b1, `THR_SEL_ADDR, 32'h12);
    wait_lvl(1'b0, n);
    chk("bad_thr_delay", 32'h1, 32'(n >= 8 && n <= 14));
    wait_lvl(1'b1, n);
    rd(`THR_SEL_ADDR, 32'h55, "thr_restored");
    rd(`FLAGS_ADDR, 32'h2, "flag_thr");
    bus(1'b1, `FLAGS_ADDR, 32'h0);
    i_model.set_code(5'h03);
    wait_lvl(1'b0, n);
    chk("bad_wdt_delay", 32'h1, 32'(n >= 8 && n <= 14));
    i_model.set_code(`WDT_CODE_ENABLE);
    wait_lvl(1'b1, n);
    rd(`FLAGS_ADDR, 32'h1, "flag_wdt");
    $display("bad code test done");
    i_model.bark();
    wait_lvl(1'b0, n);
    chk("to_normal", 32'h2, 32'({timeout_status_flag, powerdown_status_flag}));
    wait_lvl(1'b1, n);
    chk("wdt_hold", 32'h1, 32'(n >= 4 && n <= 14));
    // Sleep, then idle: partial reset only
    for (int k = 0; k < 2; k++) begin
      @(posedge hclk);
      clear_status_flags <= 1'b1;
      sleep_mode <= (k == 0);
      idle_mode <= (k == 1);
      @(posedge hclk);
      clear_status_flags <= 1'b0;
      #1;
      chk("to_cleared", 32'h0, 32'(timeout_status_flag));
      i_model.bark();
      #1;
      chk("partial", 32'h3, 32'({sys_reset_n, pc_sp_clear}));
      chk("to_pdf_sl", 32'h3, 32'({timeout_status_flag, powerdown_status_flag}));
      // Default wake-up delay is 16 slow ticks, at least 64 clocks
      repeat (60) @(posedge hclk);
      #1;
      chk("wake_hold", 32'h1, 32'(pc_sp_clear));
      repeat (20) @(posedge hclk);
      #1;
      chk("wake", 32'h0, 32'(pc_sp_clear));
      @(posedge hclk);
      sleep_mode <= 1'b0;
      idle_mode <= 1'b0;
      rd(`THR_SEL_ADDR, 32'h55, "thr_sleep");
    end
    // Status: running, lowest level, time-out and power-down flags set
    rd(`STATUS_ADDR, 32'h13, "status");
    $display("watchdog test done");
    // Interrupt: all four events seen, masked, enabled, cleared
    bus(1'b1, `IRQ_EN_ADDR, 32'h0);
    rd(`IRQ_STAT_ADDR, 32'hF, "irq_stat");
    #1;
    chk("irq_masked", 32'h0, 32'(irq));
    bus(1'b1, `IRQ_EN_ADDR, 32'h8);
    rd(`IRQ_EN_ADDR, 32'h8, "irq_en");
    #1;
    chk("irq_on", 32'h1, 32'(irq));
    bus(1'b1, `IRQ_CLR_ADDR, 32'h8);
    bus(1'b1, `IRQ_STAT_ADDR, 32'h0);
    rd(`IRQ_STAT_ADDR, 32'h7, "irq_clr");
    #1;
    chk("irq_off", 32'h0, 32'(irq));
    // Unselected transfer must leave the enables alone
    @(posedge hclk);
    htrans <= 2'h2;
    hwrite <= 1'b1;
    haddr <= 32'(`IRQ_EN_ADDR);
    @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= 32'hF;
    rd(`IRQ_EN_ADDR, 32'h8, "irq_en_unsel");
    rd(8'h40, 32'h0, "unmapped");
    $display("interrupt test done");
    // Mid-run power-on: everything returns to its power-on values
    bus(1'b1, `THR_SEL_ADDR, 32'h33);
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    #1;
    chk("por2_hold", 32'h3, 32'({port_preset, pc_sp_clear}));
    chk("por2_to_pdf", 32'h0, 32'({timeout_status_flag, powerdown_status_flag}));
    rd(`THR_SEL_ADDR, 32'h55, "thr_por2");
    rd(`IRQ_STAT_ADDR, 32'h0, "irq_por2");
    $display("second reset test done");
    summarize;
  end
endmodule : test_mcu_reset_sources_and_flags
